// >>> hw/nfc_command_port.sv
// NOR flash bus interface, command port and program/erase engine model.
// Host pins are synchronous to core_clk_i; pin active-low levels are named _n.
`timescale 1ns/1ns
module nfc_command_port
  import nfc_pkg::*;
(
  input wire logic core_clk_i,
  input wire logic rst_i,
  input wire logic rst_pin_n_i,
  input wire logic chip_sel_n_i,
  input wire logic out_en_n_i,
  input wire logic write_n_i,
  input wire logic address_valid_n_i,
  input wire logic sync_mode_i,
  input wire logic [ADDR_W-1:0] addr_i,
  input wire logic [DATA_W-1:0] dq_i,
  output logic [DATA_W-1:0] dq_o,
  output logic dq_oe_o,
  output logic wait_o,
  output logic wait_oe_o,
  output logic busy_o,
  output logic standby_o,
  output logic invalid_flag_o,
  output logic [ADDR_W-1:0] invalid_addr_o,
  output logic lock_cmd_o,
  output logic [1:0] lock_action_o,
  output logic [ADDR_W-1:0] lock_addr_o,
  output logic [15:0] read_config_value_o
);

  ////////////////////////////////////////////////////////////////////////////
  logic active;
  logic prev_bus_wr;
  logic prev_ce_n;
  logic bus_wr;
  logic wr_strobe;
  logic [ADDR_W-1:0] latched_addr;
  logic [ADDR_W-1:0] eff_addr;
  nfc_write_t wr;
  nfc_read_mode_t read_mode;
  nfc_cmd_state_t cmd_state;
  nfc_engine_op_t eng_op;
  nfc_engine_req_t req;
  logic [7:0] status_read_value;
  logic [15:0] eng_count;
  logic suspended;
  logic word_prog_busy;
  logic [4:0] buf_count;
  logic [4:0] buf_fill;
  logic [DATA_W-1:0] buf_mem [BUF_WORDS];
  logic [7:0] cmd;

  assign active = rst_pin_n_i;
  assign bus_wr = active && !chip_sel_n_i && !write_n_i && out_en_n_i;
  // Write ends on first rising strobe; a strobe after bad conditions counts nothing
  assign wr_strobe = active && out_en_n_i && prev_bus_wr
    && (write_n_i || chip_sel_n_i);
  assign cmd = wr.data[7:0];
  assign word_prog_busy = (eng_op == NFC_ENG_PROG) && !suspended;

  ////////////////////////////////////////////////////////////////////////////
  always_ff @(posedge core_clk_i)
  begin
    if (rst_i)
    begin
      prev_bus_wr <= 1'b0;
      prev_ce_n <= 1'b1;
    end
    else
    begin
      prev_bus_wr <= bus_wr;
      prev_ce_n <= chip_sel_n_i;
    end
  end

  // Address latch; sync capture is on the clock while valid and select are low and write is high
  always_ff @(posedge core_clk_i)
  begin
    if (rst_i)
      latched_addr <= '0;
    else if (!address_valid_n_i && active)
    begin
      if (!sync_mode_i)
        latched_addr <= addr_i;
      else if (!write_n_i || chip_sel_n_i)
        latched_addr <= latched_addr;
      else
        latched_addr <= addr_i;
    end
  end
  // Transparent path in asynchronous mode while valid is low
  assign eff_addr = (!sync_mode_i && !address_valid_n_i) ? addr_i : latched_addr;

  always_ff @(posedge core_clk_i)
  begin
    if (rst_i)
      wr <= '0;
    else if (bus_wr)
      wr <= '{addr: addr_i, data: dq_i};
  end

  ////////////////////////////////////////////////////////////////////////////
  // Command decode; any address is accepted
  always_ff @(posedge core_clk_i)
  begin
    if (rst_i || !active)
    begin
      cmd_state <= NFC_CP_IDLE;
      read_mode <= NFC_RD_ARRAY;
      req <= '0;
      buf_count <= '0;
      buf_fill <= '0;
      lock_cmd_o <= 1'b0;
      lock_action_o <= 2'b00;
      lock_addr_o <= '0;
      read_config_value_o <= '0;
    end
    else
    begin
      req.start <= 1'b0;
      lock_cmd_o <= 1'b0;
      if (wr_strobe)
      begin
        unique case (cmd_state)
          NFC_CP_IDLE:
          begin
            if (word_prog_busy)
            begin
              if (cmd == CMD_READ_STATUS)
                read_mode <= NFC_RD_STATUS;
            end
            else if (cmd == CMD_READ_ARRAY)
              read_mode <= NFC_RD_ARRAY;
            else if (cmd == CMD_READ_STATUS)
              read_mode <= NFC_RD_STATUS;
            else if (cmd == CMD_READ_ID)
              read_mode <= NFC_RD_ID;
            else if (cmd == CMD_READ_QUERY)
              read_mode <= NFC_RD_QUERY;
            else if (cmd == CMD_WORD_PROG || cmd == CMD_WORD_PROG_ALT)
              cmd_state <= NFC_CP_WORD_DATA;
            else if (cmd == CMD_BUF_PROG)
              cmd_state <= NFC_CP_BUF_COUNT;
            else if (cmd == CMD_BURST_SETUP)
              cmd_state <= NFC_CP_BURST_CONFIRM;
            else if (cmd == CMD_ERASE)
              cmd_state <= NFC_CP_ERASE_CONFIRM;
            else if (cmd == CMD_LOCK_SETUP)
            begin
              cmd_state <= NFC_CP_LOCK_ACTION;
              lock_addr_o <= wr.addr;
            end
            else if (cmd == CMD_OTP_PROG)
              cmd_state <= NFC_CP_OTP_DATA;
          end
          NFC_CP_WORD_DATA:
          begin
            cmd_state <= NFC_CP_IDLE;
            req <= '{start: 1'b1, erase: 1'b0, addr: wr.addr};
            read_mode <= NFC_RD_STATUS;
          end
          NFC_CP_BUF_COUNT:
          begin
            buf_count <= wr.data[4:0];
            buf_fill <= '0;
            cmd_state <= NFC_CP_BUF_DATA;
          end
          NFC_CP_BUF_DATA:
          begin
            buf_fill <= buf_fill + 5'h01;
            if (buf_fill == buf_count || buf_fill == BUF_LAST)
              cmd_state <= NFC_CP_BUF_CONFIRM;
          end
          NFC_CP_BUF_CONFIRM:
          begin
            cmd_state <= NFC_CP_IDLE;
            if (cmd == CMD_CONFIRM)
            begin
              req <= '{start: 1'b1, erase: 1'b0, addr: wr.addr};
              read_mode <= NFC_RD_STATUS;
            end
          end
          NFC_CP_BURST_CONFIRM:
          begin
            if (cmd == CMD_CONFIRM)
            begin
              cmd_state <= NFC_CP_BURST_DATA;
              read_mode <= NFC_RD_STATUS;
            end
            else
              cmd_state <= NFC_CP_IDLE;
          end
          NFC_CP_BURST_DATA:
          begin
            // Burst mode stays until reset; every write requests a program at its address, started only if the engine is idle
            req <= '{start: 1'b1, erase: 1'b0, addr: wr.addr};
          end
          NFC_CP_ERASE_CONFIRM:
          begin
            cmd_state <= NFC_CP_IDLE;
            if (cmd == CMD_CONFIRM)
            begin
              req <= '{start: 1'b1, erase: 1'b1, addr: wr.addr};
              read_mode <= NFC_RD_STATUS;
            end
          end
          NFC_CP_LOCK_ACTION:
          begin
            cmd_state <= NFC_CP_IDLE;
            if (cmd == CMD_LOCK || cmd == CMD_CONFIRM || cmd == CMD_LOCK_DOWN)
            begin
              lock_cmd_o <= 1'b1;
              lock_action_o <= (cmd == CMD_LOCK) ? 2'b01 :
                (cmd == CMD_CONFIRM) ? 2'b10 : 2'b11;
            end
            else if (cmd == CMD_READ_CONFIG)
              read_config_value_o <= lock_addr_o[15:0] | wr.addr[15:0];
          end
          NFC_CP_OTP_DATA:
          begin
            cmd_state <= NFC_CP_IDLE;
            req <= '{start: 1'b1, erase: 1'b0, addr: wr.addr};
            read_mode <= NFC_RD_STATUS;
          end
          default:
            cmd_state <= NFC_CP_IDLE;
        endcase
      end
    end
  end

  always_ff @(posedge core_clk_i)
  begin
    if (cmd_state == NFC_CP_BUF_DATA && wr_strobe)
      buf_mem[buf_fill] <= wr.data;
  end

  ////////////////////////////////////////////////////////////////////////////
  // Program/erase engine; chip select plays no part, so deselect never stops it
  always_ff @(posedge core_clk_i)
  begin
    if (rst_i)
    begin
      eng_op <= NFC_ENG_IDLE;
      eng_count <= '0;
      suspended <= 1'b0;
      status_read_value <= STATUS_RESET;
      invalid_flag_o <= 1'b0;
      invalid_addr_o <= '0;
    end
    else if (!active)
    begin
      if (eng_op != NFC_ENG_IDLE)
      begin
        invalid_flag_o <= 1'b1;
        invalid_addr_o <= req.addr;
      end
      eng_op <= NFC_ENG_IDLE;
      suspended <= 1'b0;
      status_read_value <= STATUS_RESET;
    end
    else if (req.start && eng_op == NFC_ENG_IDLE)
    begin
      eng_op <= req.erase ? NFC_ENG_ERASE : NFC_ENG_PROG;
      eng_count <= req.erase ? ERASE_CYCLES : PROG_CYCLES;
      status_read_value[ST_READY] <= 1'b0;
      invalid_flag_o <= 1'b0;
    end
    else if (wr_strobe && cmd_state == NFC_CP_IDLE && eng_op != NFC_ENG_IDLE
      && !suspended && cmd == CMD_SUSPEND)
    begin
      suspended <= 1'b1;
      status_read_value[ST_READY] <= 1'b1;
      status_read_value[(eng_op == NFC_ENG_ERASE) ? ST_ERASE_SUSP : ST_PROG_SUSP] <= 1'b1;
    end
    else if (wr_strobe && cmd_state == NFC_CP_IDLE && suspended && cmd == CMD_CONFIRM)
    begin
      suspended <= 1'b0;
      status_read_value[ST_READY] <= 1'b0;
      status_read_value[ST_ERASE_SUSP] <= 1'b0;
      status_read_value[ST_PROG_SUSP] <= 1'b0;
    end
    else if (eng_op != NFC_ENG_IDLE && !suspended)
    begin
      eng_count <= eng_count - 16'h0001;
      if (eng_count == 16'h0001)
      begin
        eng_op <= NFC_ENG_IDLE;
        status_read_value[ST_READY] <= 1'b1;
      end
    end
    else if (wr_strobe && cmd_state == NFC_CP_IDLE && eng_op == NFC_ENG_IDLE
      && cmd == CMD_CLEAR_STATUS)
      status_read_value <= status_read_value & ~ST_ERR_MASK;
  end
  assign busy_o = (eng_op != NFC_ENG_IDLE);
  assign standby_o = chip_sel_n_i || !active;

  ////////////////////////////////////////////////////////////////////////////
  // Read path; status sampled at access start so it stays fixed within one access
  always_ff @(posedge core_clk_i)
  begin
    if (rst_i)
      dq_o <= '0;
    else if (prev_ce_n || !chip_sel_n_i && out_en_n_i || read_mode == NFC_RD_ARRAY)
    begin
      unique case (read_mode)
        NFC_RD_ARRAY: dq_o <= buf_mem[eff_addr[4:0]];
        NFC_RD_STATUS: dq_o <= {8'h00, status_read_value};
        NFC_RD_ID: dq_o <= {8'h00, ID_CODE};
        NFC_RD_QUERY: dq_o <= QUERY_CODE;
      endcase
    end
  end
  assign dq_oe_o = active && !chip_sel_n_i && !out_en_n_i && write_n_i;
  assign wait_o = 1'b0;
  assign wait_oe_o = dq_oe_o && sync_mode_i;

  ////////////////////////////////////////////////////////////////////////////
  property p_float_when_reset;
    @(posedge core_clk_i) disable iff (rst_i) !rst_pin_n_i |-> !dq_oe_o && !wait_oe_o;
  endproperty
  a_float_when_reset: assert property (p_float_when_reset)
    else $error("outputs driven during pin reset");
  property p_float_oe_high;
    @(posedge core_clk_i) disable iff (rst_i) out_en_n_i || chip_sel_n_i |-> !dq_oe_o;
  endproperty
  a_float_oe_high: assert property (p_float_oe_high)
    else $error("data driven while disabled");
  property p_status_after_reset;
    @(posedge core_clk_i) disable iff (rst_i)
      $rose(rst_pin_n_i) |-> status_read_value == STATUS_RESET && read_mode == NFC_RD_ARRAY;
  endproperty
  a_status_after_reset: assert property (p_status_after_reset)
    else $error("bad state after reset release");
  property p_abort_invalid;
    @(posedge core_clk_i) disable iff (rst_i)
      busy_o && !rst_pin_n_i |=> invalid_flag_o && !busy_o;
  endproperty
  a_abort_invalid: assert property (p_abort_invalid)
    else $error("abort not flagged");
  property p_prog_status_mode;
    @(posedge core_clk_i) disable iff (rst_i)
      wr_strobe && active && cmd_state == NFC_CP_WORD_DATA |=> read_mode == NFC_RD_STATUS
        ##1 busy_o;
  endproperty
  a_prog_status_mode: assert property (p_prog_status_mode)
    else $error("program did not start with status mode");
  property p_deselect_keeps_busy;
    @(posedge core_clk_i) disable iff (rst_i)
      busy_o && !suspended && eng_count > 16'h0001 && active ##1 active |-> busy_o;
  endproperty
  a_deselect_keeps_busy: assert property (p_deselect_keeps_busy)
    else $error("operation stopped early");
  property p_suspend;
    @(posedge core_clk_i) disable iff (rst_i)
      wr_strobe && active && cmd_state == NFC_CP_IDLE && busy_o && !suspended
        && cmd == CMD_SUSPEND && !req.start |=> suspended && status_read_value[ST_READY];
  endproperty
  a_suspend: assert property (p_suspend)
    else $error("suspend not taken");
  property p_bad_write_ignored;
    @(posedge core_clk_i) disable iff (rst_i)
      !out_en_n_i && !write_n_i && !chip_sel_n_i |=> !wr_strobe;
  endproperty
  a_bad_write_ignored: assert property (p_bad_write_ignored)
    else $error("write taken with output enable low");
  property p_word_prog_filter;
    @(posedge core_clk_i) disable iff (rst_i)
      wr_strobe && active && word_prog_busy && cmd_state == NFC_CP_IDLE
        && cmd != CMD_READ_STATUS |=> read_mode == $past(read_mode);
  endproperty
  a_word_prog_filter: assert property (p_word_prog_filter)
    else $error("command honoured during word program");
  c_erase: cover property (@(posedge core_clk_i) disable iff (rst_i) eng_op == NFC_ENG_ERASE);
  c_suspend: cover property (@(posedge core_clk_i) disable iff (rst_i) suspended);
  c_burst: cover property (@(posedge core_clk_i) disable iff (rst_i)
    cmd_state == NFC_CP_BURST_DATA);
  c_lock: cover property (@(posedge core_clk_i) disable iff (rst_i) lock_cmd_o);
endmodule

// >>> hw/nfc_pkg.sv
// Package for the NOR flash bus command port: command codes, modes, carriers.
// Assumes a single core clock; all pins presented synchronous to it.
package nfc_pkg;
  localparam int ADDR_W = 24;
  localparam int DATA_W = 16;
  localparam int BUF_WORDS = 32;
  localparam logic [7:0] CMD_READ_ARRAY = 8'hff;
  localparam logic [7:0] CMD_READ_STATUS = 8'h70;
  localparam logic [7:0] CMD_READ_ID = 8'h90;
  localparam logic [7:0] CMD_READ_QUERY = 8'h98;
  localparam logic [7:0] CMD_CLEAR_STATUS = 8'h50;
  localparam logic [7:0] CMD_WORD_PROG = 8'h40;
  localparam logic [7:0] CMD_WORD_PROG_ALT = 8'h10;
  localparam logic [7:0] CMD_BUF_PROG = 8'he8;
  localparam logic [7:0] CMD_CONFIRM = 8'hd0;
  localparam logic [7:0] CMD_BURST_SETUP = 8'h80;
  localparam logic [7:0] CMD_ERASE = 8'h20;
  localparam logic [7:0] CMD_SUSPEND = 8'hb0;
  localparam logic [7:0] CMD_LOCK_SETUP = 8'h60;
  localparam logic [7:0] CMD_LOCK = 8'h01;
  localparam logic [7:0] CMD_LOCK_DOWN = 8'h2f;
  localparam logic [7:0] CMD_READ_CONFIG = 8'h03;
  localparam logic [7:0] CMD_OTP_PROG = 8'hc0;
  localparam logic [7:0] STATUS_RESET = 8'h80;
  localparam int ST_READY = 7;
  localparam int ST_ERASE_SUSP = 6;
  localparam int ST_ERASE_ERR = 5;
  localparam int ST_PROG_ERR = 4;
  localparam int ST_PROG_SUSP = 2;
  localparam logic [7:0] ST_ERR_MASK = 8'h3a;
  localparam logic [7:0] ID_CODE = 8'h5a; // Arbitrary value
  localparam logic [15:0] QUERY_CODE = 16'h0051;
  localparam logic [4:0] BUF_LAST = 5'h1f;
  localparam logic [15:0] PROG_CYCLES = 16'h0010;
  localparam logic [15:0] ERASE_CYCLES = 16'h0040;

  typedef enum logic [1:0] {
    NFC_RD_ARRAY = 2'b00,
    NFC_RD_STATUS = 2'b01,
    NFC_RD_ID = 2'b10,
    NFC_RD_QUERY = 2'b11
  } nfc_read_mode_t;

  typedef enum logic [3:0] {
    NFC_CP_IDLE = 4'h0,
    NFC_CP_WORD_DATA = 4'h1,
    NFC_CP_BUF_COUNT = 4'h2,
    NFC_CP_BUF_DATA = 4'h3,
    NFC_CP_BUF_CONFIRM = 4'h4,
    NFC_CP_BURST_CONFIRM = 4'h5,
    NFC_CP_BURST_DATA = 4'h6,
    NFC_CP_ERASE_CONFIRM = 4'h7,
    NFC_CP_LOCK_ACTION = 4'h8,
    NFC_CP_OTP_DATA = 4'h9
  } nfc_cmd_state_t;

  typedef enum logic [1:0] {
    NFC_ENG_IDLE = 2'b00,
    NFC_ENG_PROG = 2'b01,
    NFC_ENG_ERASE = 2'b10
  } nfc_engine_op_t;

  typedef struct packed {
    logic [ADDR_W-1:0] addr;
    logic [DATA_W-1:0] data;
  } nfc_write_t;

  typedef struct packed {
    logic start;
    logic erase;
    logic [ADDR_W-1:0] addr;
  } nfc_engine_req_t;
endpackage

// >>> sim/nfc_host_model.sv
// Host-side bus model: drives select, enables, strobe, address and write data.
// Assumes the bench calls its tasks; pins change only at falling edges.
`timescale 1ns/1ns
module nfc_host_model
  import nfc_pkg::*;
(
  input wire logic core_clk_i,
  output logic rst_pin_n_o,
  output logic chip_sel_n_o,
  output logic out_en_n_o,
  output logic write_n_o,
  output logic address_valid_n_o,
  output logic [ADDR_W-1:0] addr_o,
  output logic [DATA_W-1:0] dq_o,
  output logic sample_o
);
  initial
  begin
    rst_pin_n_o = 1'b1;
    chip_sel_n_o = 1'b1;
    out_en_n_o = 1'b1;
    write_n_o = 1'b1;
    address_valid_n_o = 1'b0;
    addr_o = '0;
    dq_o = 16'h0000;
    sample_o = 1'b0;
  end

  ////////////////////////////////////////////////////////////////////////////
  // One write per strobe; bad set pulls output enable low as a fault
  task automatic bus_wr(input logic [ADDR_W-1:0] a, input logic [DATA_W-1:0] d,
                        input logic bad);
    @(negedge core_clk_i);
    chip_sel_n_o = 1'b0;
    write_n_o = 1'b0;
    out_en_n_o = ~bad;
    addr_o = a;
    dq_o = d;
    @(negedge core_clk_i);
    write_n_o = 1'b1;
    chip_sel_n_o = 1'b1;
    out_en_n_o = 1'b1;
    // Released bus shows the inverse, never the stale word
    dq_o = ~d;
    @(negedge core_clk_i);
  endtask

  // Select and enable toggle per access so status refreshes
  task automatic bus_rd(input logic [ADDR_W-1:0] a);
    @(negedge core_clk_i);
    chip_sel_n_o = 1'b0;
    out_en_n_o = 1'b0;
    addr_o = a;
    @(negedge core_clk_i);
    sample_o = 1'b1;
    @(negedge core_clk_i);
    sample_o = 1'b0;
    chip_sel_n_o = 1'b1;
    out_en_n_o = 1'b1;
  endtask
endmodule

// >>> sim/nfc_command_port_tb_top.sv
// Self-checking bench for the NOR flash command port.
// Assumes the host model drives all bus pins; reads checked from a queue.
`timescale 1ns/1ns
module nfc_command_port_tb_top;
  import nfc_pkg::*;
  logic core_clk_i = 1'b0;
  logic rst_i = 1'b1;
  logic sync_mode_i = 1'b0;
  logic rst_pin_n, chip_sel_n, out_en_n, write_n, address_valid_n, sample;
  logic [ADDR_W-1:0] addr, wa, invalid_addr_o, lock_addr_o;
  logic [DATA_W-1:0] dq_i, dq_o, read_config_value_o;
  logic dq_oe_o, wait_o, wait_oe_o, busy_o, standby_o, invalid_flag_o, lock_cmd_o;
  logic [1:0] lock_action_o;
  logic [31:0] seed = 32'he259;
  logic [31:0] r;
  logic [DATA_W-1:0] buf_words [32];
  logic [31:0] rdq [$];
  logic [25:0] lkq [$];
  int n_errors = 0;
  int compares = 0;

  always #5 core_clk_i = ~core_clk_i;

  nfc_host_model nfc_host_model_i (.core_clk_i(core_clk_i), .rst_pin_n_o(rst_pin_n),
    .chip_sel_n_o(chip_sel_n), .out_en_n_o(out_en_n), .write_n_o(write_n),
    .address_valid_n_o(address_valid_n), .addr_o(addr), .dq_o(dq_i), .sample_o(sample));

  nfc_command_port nfc_command_port_i (.core_clk_i(core_clk_i), .rst_i(rst_i),
    .rst_pin_n_i(rst_pin_n), .chip_sel_n_i(chip_sel_n), .out_en_n_i(out_en_n),
    .write_n_i(write_n), .address_valid_n_i(address_valid_n), .sync_mode_i(sync_mode_i),
    .addr_i(addr), .dq_i(dq_i), .dq_o(dq_o), .dq_oe_o(dq_oe_o), .wait_o(wait_o),
    .wait_oe_o(wait_oe_o), .busy_o(busy_o), .standby_o(standby_o),
    .invalid_flag_o(invalid_flag_o), .invalid_addr_o(invalid_addr_o),
    .lock_cmd_o(lock_cmd_o), .lock_action_o(lock_action_o), .lock_addr_o(lock_addr_o),
    .read_config_value_o(read_config_value_o));

  ////////////////////////////////////////////////////////////////////////////
  function automatic logic [31:0] rnd();
    seed ^= seed << 13;
    seed ^= seed >> 17;
    seed ^= seed << 5;
    return seed;
  endfunction

  task automatic cmp_val(input logic [31:0] got, input logic [31:0] exp);
    compares++;
    if (got !== exp)
    begin
      n_errors++;
      $display("[FAIL] %0t got %h exp %h", $time, got, exp);
    end
  endtask

  task automatic conclude();
    $display("compares %0d n_errors %0d", compares, n_errors);
    if (n_errors == 0 && compares > 0)
      $display("SIMULATION PASSED");
    else
      $display("SIMULATION FAILED");
    $finish;
  endtask

  task automatic cw(input logic [ADDR_W-1:0] a, input logic [7:0] c);
    nfc_host_model_i.bus_wr(a, {8'h00, c}, 1'b0);
  endtask

  // Note the expected word, then read; mask picks the meaningful lanes
  task automatic rd_exp(input logic [ADDR_W-1:0] a, input logic [15:0] m,
                        input logic [15:0] e);
    rdq.push_back({m, e});
    nfc_host_model_i.bus_rd(a);
  endtask

  // Bounded wait; select stays high meanwhile so the engine runs deselected
  task automatic wait_idle();
    int i;
    for (i = 0; i < 300 && busy_o !== 1'b0; i++)
      @(negedge core_clk_i);
    if (busy_o !== 1'b0)
    begin
      n_errors++;
      conclude();
    end
  endtask

  ////////////////////////////////////////////////////////////////////////////
  // Monitor: a read sample or a lock pulse takes the oldest note
  always @(posedge core_clk_i)
  begin
    if (sample === 1'b1)
    begin
      r = rdq.pop_front();
      cmp_val({16'h0, dq_o & r[31:16]}, {16'h0, r[15:0]});
    end
    if (lock_cmd_o === 1'b1)
      cmp_val({lock_action_o, lock_addr_o}, lkq.size() ? lkq.pop_front() : '1);
  end

  ////////////////////////////////////////////////////////////////////////////
  initial
  begin
    repeat (5) @(posedge core_clk_i);
    @(negedge core_clk_i);
    rst_i = 1'b0;
    r = rnd();
    wa = {r[23:5], 5'h00};
    cw(r[23:0], CMD_READ_STATUS);
    rd_exp(wa, 16'h00ff, {8'h00, STATUS_RESET});
    cw(wa, CMD_READ_ID);
    rd_exp(wa, 16'h00ff, {8'h00, ID_CODE});
    cw(wa, CMD_READ_QUERY);
    rd_exp(wa, 16'h00ff, QUERY_CODE & 16'h00ff);
    $display("test read modes done");
    // Full buffer is the boundary case
    cw(wa, CMD_BUF_PROG);
    cw(wa, {3'b000, BUF_LAST});
    for (int i = 0; i < BUF_WORDS; i++)
    begin
      r = rnd();
      buf_words[i] = r[15:0];
      nfc_host_model_i.bus_wr(wa + i, r[15:0], 1'b0);
    end
    cw(wa, CMD_CONFIRM);
    rd_exp(wa, 16'h0080, 16'h0000);
    wait_idle();
    cw(wa, CMD_READ_ARRAY);
    for (int i = 0; i < BUF_WORDS; i++)
      rd_exp(wa + i, 16'hffff, buf_words[i]);
    nfc_host_model_i.bus_wr(wa, {8'h00, CMD_READ_STATUS}, 1'b1);
    rd_exp(wa + 1, 16'hffff, buf_words[1]);
    $display("test buffered program done");
    cw(wa, CMD_WORD_PROG_ALT);
    nfc_host_model_i.bus_wr(wa + 2, buf_words[2], 1'b0);
    @(negedge core_clk_i);
    cmp_val(busy_o, 1'b1);
    cw(wa, CMD_READ_ARRAY);
    rd_exp(wa, 16'h0080, 16'h0000);
    cw(wa, CMD_SUSPEND);
    rd_exp(wa, 16'h0004, 16'h0004);
    cw(wa, CMD_CONFIRM);
    cmp_val(busy_o, 1'b1);
    wait_idle();
    rd_exp(wa, 16'h00ff, {8'h00, STATUS_RESET});
    $display("test word program suspend done");
    cw(wa + 7, CMD_ERASE);
    cw(wa + 7, CMD_CONFIRM);
    @(negedge core_clk_i);
    cmp_val(busy_o, 1'b1);
    @(negedge core_clk_i);
    nfc_host_model_i.rst_pin_n_o = 1'b0;
    nfc_host_model_i.chip_sel_n_o = 1'b0;
    nfc_host_model_i.out_en_n_o = 1'b0;
    repeat (2) @(negedge core_clk_i);
    cmp_val({dq_oe_o, wait_oe_o, standby_o, busy_o}, 4'b0010);
    cmp_val({invalid_flag_o, invalid_addr_o}, {1'b1, wa + 24'h000007});
    nfc_host_model_i.chip_sel_n_o = 1'b1;
    nfc_host_model_i.out_en_n_o = 1'b1;
    nfc_host_model_i.rst_pin_n_o = 1'b1;
    // Wake-up gap before the first access
    repeat (2) @(negedge core_clk_i);
    cw(wa, CMD_READ_STATUS);
    rd_exp(wa, 16'h00ff, {8'h00, STATUS_RESET});
    $display("test erase abort done");
    // Lock, unlock, lock-down in turn
    for (int i = 1; i < 4; i++)
    begin
      lkq.push_back({i[1:0], wa + i[23:0]});
      cw(wa + i, CMD_LOCK_SETUP);
      cw(wa + i, i == 1 ? CMD_LOCK : i == 2 ? CMD_CONFIRM : CMD_LOCK_DOWN);
    end
    r = rnd();
    cw(r[23:0], CMD_LOCK_SETUP);
    cw(wa + 9, CMD_READ_CONFIG);
    cmp_val(read_config_value_o, r[15:0] | (wa[15:0] + 16'h0009));
    cmp_val(lkq.size(), 0);
    $display("test lock and config done");
    cw(wa, CMD_READ_ARRAY);
    // Sync capture needs a clock with select low before data follows
    sync_mode_i = 1'b1;
    nfc_host_model_i.addr_o = wa | 24'h000003;
    nfc_host_model_i.chip_sel_n_o = 1'b0;
    nfc_host_model_i.out_en_n_o = 1'b0;
    @(negedge core_clk_i);
    cmp_val({dq_oe_o, wait_oe_o, wait_o, standby_o}, 4'b1100);
    @(negedge core_clk_i);
    cmp_val(dq_o, buf_words[3]);
    nfc_host_model_i.out_en_n_o = 1'b1;
    @(negedge core_clk_i);
    cmp_val({dq_oe_o, wait_oe_o}, 2'b00);
    nfc_host_model_i.chip_sel_n_o = 1'b1;
    nfc_host_model_i.out_en_n_o = 1'b0;
    @(negedge core_clk_i);
    cmp_val({dq_oe_o, wait_oe_o, standby_o}, 3'b001);
    nfc_host_model_i.out_en_n_o = 1'b1;
    $display("test output enables done");
    cmp_val(rdq.size(), 0);
    conclude();
  end
endmodule
